// File: core/ssf_status_flags.v
/*
 * Status flag logic of a serial unit: transmit-empty, receive-full, overrun,
 * framing/parity error flags, hold registers and interrupt status/mask.
 * Assumes one clock, synchronous inputs, and a register master that issues
 * one-cycle strobes and takes read data in the following cycle.
 */
`timescale 1ns/1ps
`default_nettype none
`include "ssf_consts.vh"

module ssf_status_flags (
    input wire ref_clk, // 100 MHz clock
    input wire arst_n, // Asynchronous reset, active low
    input wire [3:0] regAddr, // Register address
    input wire [7:0] regWrData, // Register write data
    input wire regWrEn, // Write strobe
    input wire regRdEn, // Read strobe
    output reg [7:0] regRdData, // Read data, cycle after strobe
    input wire txLoadShift, // Pulse: hold word moved to shift register
    input wire txEndIn, // Transmit-end level from shift engine
    input wire dtcTxWrite, // Pulse: controller writes hold word
    input wire [7:0] dtcTxData, // Controller transmit word
    input wire dtcRxRead, // Pulse: controller reads hold word
    input wire rxDone, // Pulse: reception complete
    input wire [7:0] rxShiftData, // Received word from shift register
    input wire rxStopBit, // First stop bit level
    input wire rxParityBad, // Parity mismatch on this word
    input wire rxMpBit, // Received multiprocessor bit
    input wire errSignalIn, // Pulse: smart-card error signal seen
    output wire [7:0] txHoldData, // Transmit hold word
    output wire [7:0] rxHoldData, // Receive hold word
    output wire txEnable, // Transmit enable control
    output wire rxEnable, // Receive enable control
    output wire smartSelect, // Smart-card mode select
    output wire twoStopSelect, // Two stop bit mode select
    output wire rxBlocked, // Reception may not proceed
    output wire txBlocked, // Transmission may not continue
    output wire multiprocTx, // Multiprocessor transfer bit
    output wire irq // Level interrupt
);

    // ************************************************************
    // Register state
    // ************************************************************
    reg [7:0] statusFf;
    reg [7:0] nxt_status;
    reg [7:0] readOneFf;
    reg [7:0] nxt_readOne;
    reg [7:0] controlFf;
    reg [7:0] txHoldFf;
    reg [7:0] nxt_txHold;
    reg [7:0] rxHoldFf;
    reg [7:0] nxt_rxHold;
    reg [`SSF_NIRQ-1:0] irqStatFf;
    reg [`SSF_NIRQ-1:0] nxt_irqStat;
    reg [`SSF_NIRQ-1:0] irqMaskFf;
    wire [1:0] rxKind;
    wire [`SSF_NIRQ-1:0] irqEvent;
    wire wrStatus;
    wire rdStatus;
    wire rxAccept;
    wire errBlock;
    integer i;

    // Address match shared by the write and status-read decoders; the read port uses a case
    function hit;
        input [3:0] a;
        input [3:0] ofs;
        begin
            hit = (a == ofs);
        end
    endfunction

    assign wrStatus = regWrEn && hit(regAddr, `SSF_OFS_STATUS);
    assign rdStatus = regRdEn && hit(regAddr, `SSF_OFS_STATUS);

    // ************************************************************
    // Reception classification
    // ************************************************************
    ssf_rx_classify ssf_rx_classify_i (
        .rxDone(rxDone),
        .stopBit1(rxStopBit),
        .parityBad(rxParityBad),
        .smartMode(smartSelect),
        .rxKind(rxKind)
    );

    // Overrun, parity, or framing flag outside smart-card mode blocks reception; in sync mode transmission too
    assign errBlock = statusFf[`SSF_B_OVR] | statusFf[`SSF_B_PER] |
        (statusFf[`SSF_B_FER] & ~smartSelect);
    assign rxBlocked = errBlock;
    assign txBlocked = errBlock & controlFf[`SSF_C_SYNC];
    assign rxAccept = (rxKind != `SSF_RX_NONE) && !errBlock && rxEnable;

    // ************************************************************
    // Status flags and hold registers
    // ************************************************************
    // Flags are cleared first, then hardware sets applied so a set wins
    always @* begin
        nxt_status = statusFf;
        nxt_readOne = readOneFf;
        nxt_txHold = txHoldFf;
        nxt_rxHold = rxHoldFf;
        // Remember which flags software has seen as one
        if (rdStatus) begin
            nxt_readOne = readOneFf | statusFf;
        end
        // Zero clears only flags read as one; ones change nothing
        if (wrStatus) begin
            for (i = `SSF_B_PER; i <= `SSF_B_TXE; i = i + 1) begin
                if (!regWrData[i] && readOneFf[i]) begin
                    nxt_status[i] = 1'b0;
                    nxt_readOne[i] = 1'b0;
                end
            end
            // Only the transfer bit is writable; end and mp bits ignored
            nxt_status[`SSF_B_MULTIPROC_TX_BIT] = regWrData[`SSF_B_MULTIPROC_TX_BIT];
        end
        // Processor write to the transmit hold word
        if (regWrEn && hit(regAddr, `SSF_OFS_TXHOLD)) begin
            nxt_txHold = regWrData;
        end
        // Controller service of the transmit request
        if (dtcTxWrite) begin
            nxt_txHold = dtcTxData;
            nxt_status[`SSF_B_TXE] = 1'b0;
        end
        // Controller service of the receive request
        if (dtcRxRead) begin
            nxt_status[`SSF_B_RXF] = 1'b0;
        end
        if (txLoadShift) begin
            nxt_status[`SSF_B_TXE] = 1'b1;
        end
        if (!txEnable) begin
            nxt_status[`SSF_B_TXE] = 1'b1;
        end
        // Receive enable has no effect on flags already set
        if (rxAccept) begin
            if (statusFf[`SSF_B_RXF]) begin
                nxt_status[`SSF_B_OVR] = 1'b1;
            end else begin
                nxt_rxHold = rxShiftData;
                nxt_status[`SSF_B_MPB] = rxMpBit;
                case (rxKind)
                    `SSF_RX_OK: nxt_status[`SSF_B_RXF] = 1'b1;
                    `SSF_RX_FER: nxt_status[`SSF_B_FER] = 1'b1;
                    `SSF_RX_PER: nxt_status[`SSF_B_PER] = 1'b1;
                    default: nxt_status[`SSF_B_RXF] = statusFf[`SSF_B_RXF];
                endcase
            end
        end
        // Smart-card error signal reuses bit 4
        if (smartSelect && errSignalIn) begin
            nxt_status[`SSF_B_FER] = 1'b1;
        end
        nxt_status[`SSF_B_TX_END_FLAG] = txEndIn;
    end

    // ************************************************************
    // Interrupt status and mask
    // ************************************************************
    assign irqEvent[`SSF_I_TXE] = ~statusFf[`SSF_B_TXE] & nxt_status[`SSF_B_TXE];
    assign irqEvent[`SSF_I_RXF] = ~statusFf[`SSF_B_RXF] & nxt_status[`SSF_B_RXF];
    assign irqEvent[`SSF_I_OVR] = ~statusFf[`SSF_B_OVR] & nxt_status[`SSF_B_OVR];
    assign irqEvent[`SSF_I_FER] = ~statusFf[`SSF_B_FER] & nxt_status[`SSF_B_FER];
    assign irqEvent[`SSF_I_PER] = ~statusFf[`SSF_B_PER] & nxt_status[`SSF_B_PER];

    // Write one to clear; a same-cycle event keeps its bit
    always @* begin
        nxt_irqStat = irqStatFf;
        if (regWrEn && hit(regAddr, `SSF_OFS_IRQ_STAT)) begin
            nxt_irqStat = irqStatFf & ~regWrData[`SSF_NIRQ-1:0];
        end
        nxt_irqStat = nxt_irqStat | irqEvent;
    end

    assign irq = |(irqStatFf & irqMaskFf);

    // ************************************************************
    // Clocked state
    // ************************************************************
    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            statusFf <= `SSF_RST_STATUS;
            readOneFf <= `SSF_RST_BYTE;
            controlFf <= `SSF_RST_CONTROL;
            txHoldFf <= `SSF_RST_BYTE;
            rxHoldFf <= `SSF_RST_BYTE;
            irqStatFf <= `SSF_RST_IRQ;
            irqMaskFf <= `SSF_RST_IRQ;
        end else begin
            statusFf <= nxt_status;
            readOneFf <= nxt_readOne;
            txHoldFf <= nxt_txHold;
            rxHoldFf <= nxt_rxHold;
            irqStatFf <= nxt_irqStat;
            if (regWrEn && hit(regAddr, `SSF_OFS_CONTROL)) begin
                controlFf <= regWrData;
            end
            if (regWrEn && hit(regAddr, `SSF_OFS_IRQ_MASK)) begin
                irqMaskFf <= regWrData[`SSF_NIRQ-1:0];
            end
        end
    end

    // ************************************************************
    // Read port
    // ************************************************************
    // Data stands only in the cycle after the strobe; zero otherwise
    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            regRdData <= `SSF_RST_BYTE;
        end else if (regRdEn) begin
            case (regAddr)
                `SSF_OFS_STATUS: regRdData <= statusFf;
                `SSF_OFS_CONTROL: regRdData <= controlFf;
                `SSF_OFS_TXHOLD: regRdData <= txHoldFf;
                `SSF_OFS_RXHOLD: regRdData <= rxHoldFf;
                `SSF_OFS_IRQ_STAT: regRdData <= {3'h0, irqStatFf};
                `SSF_OFS_IRQ_MASK: regRdData <= {3'h0, irqMaskFf};
                default: regRdData <= `SSF_RST_BYTE;
            endcase
        end else begin
            regRdData <= `SSF_RST_BYTE;
        end
    end

    assign txHoldData = txHoldFf;
    assign rxHoldData = rxHoldFf;
    assign txEnable = controlFf[`SSF_C_TXEN];
    assign rxEnable = controlFf[`SSF_C_RXEN];
    assign smartSelect = controlFf[`SSF_C_SMART];
    assign twoStopSelect = controlFf[`SSF_C_TWOSTOP];
    assign multiprocTx = statusFf[`SSF_B_MULTIPROC_TX_BIT];

endmodule // ssf_status_flags
`default_nettype wire

// File: core/ssf_consts.vh
/*
 * Constants for the serial status flag block: register offsets, bit positions,
 * reset values and event codes.
 * Assumes it is included by bare name from the core design files.
 */
`ifndef SSF_CONSTS_VH
`define SSF_CONSTS_VH

// Register offsets on the plain register port
`define SSF_ADDR_W 4
`define SSF_OFS_STATUS 4'h0
`define SSF_OFS_CONTROL 4'h1
`define SSF_OFS_TXHOLD 4'h2
`define SSF_OFS_RXHOLD 4'h3
`define SSF_OFS_IRQ_STAT 4'h4
`define SSF_OFS_IRQ_MASK 4'h5

// Status bit positions
`define SSF_B_TXE 7
`define SSF_B_RXF 6
`define SSF_B_OVR 5
`define SSF_B_FER 4
`define SSF_B_PER 3
`define SSF_B_TX_END_FLAG 2
`define SSF_B_MPB 1
`define SSF_B_MULTIPROC_TX_BIT 0

// Control bit positions
`define SSF_C_TXEN 0
`define SSF_C_RXEN 1
`define SSF_C_SMART 2
`define SSF_C_SYNC 3
`define SSF_C_TWOSTOP 4

// Reset values
`define SSF_RST_STATUS 8'h84
`define SSF_RST_CONTROL 8'h00
`define SSF_RST_BYTE 8'h00
`define SSF_RST_IRQ 5'h00

// Interrupt event bit positions
`define SSF_I_TXE 0
`define SSF_I_RXF 1
`define SSF_I_OVR 2
`define SSF_I_FER 3
`define SSF_I_PER 4
`define SSF_NIRQ 5

// Reception outcome codes
`define SSF_RX_NONE 2'h0
`define SSF_RX_OK 2'h1
`define SSF_RX_FER 2'h2
`define SSF_RX_PER 2'h3

`endif

// File: core/ssf_rx_classify.v
/*
 * Classifies a completed reception into ok, framing error or parity error.
 * Assumes stop and parity indications arrive together with the done pulse.
 */
`timescale 1ns/1ps
`default_nettype none
`include "ssf_consts.vh"

module ssf_rx_classify (
    input wire rxDone, // One-cycle reception complete
    input wire stopBit1, // First stop bit level
    input wire parityBad, // Parity mismatch seen
    input wire smartMode, // Smart-card mode selected
    output reg [1:0] rxKind // Reception outcome code
);

    // Stop bit low is framing error; smart-card mode has no framing check.
    // Only the first stop bit is looked at, so two-stop mode needs nothing extra.
    always @* begin
        rxKind = `SSF_RX_NONE;
        if (rxDone) begin
            if (!stopBit1 && !smartMode) begin
                rxKind = `SSF_RX_FER;
            end else if (parityBad) begin
                rxKind = `SSF_RX_PER;
            end else begin
                rxKind = `SSF_RX_OK;
            end
        end
    end

endmodule // ssf_rx_classify
`default_nettype wire

// File: tb/ssf_status_flags_asserts.sv
/* Port-level checker for the status flag block.
   Assumes it is bound onto ssf_status_flags and sees only its ports. */
`timescale 1ns/1ps
`default_nettype none
module ssf_status_flags_asserts (
    input wire logic ref_clk, // Clock
    input wire logic arst_n, // Reset, active low
    input wire logic [3:0] regAddr, // Register address
    input wire logic [7:0] regWrData, // Write data
    input wire logic regWrEn, // Write strobe
    input wire logic regRdEn, // Read strobe
    input wire logic [7:0] regRdData, // Read data
    input wire logic dtcTxWrite, // Controller hold write
    input wire logic [7:0] dtcTxData, // Controller word
    input wire logic rxDone, // Reception complete
    input wire logic [7:0] rxHoldData, // Receive hold word
    input wire logic [7:0] txHoldData, // Transmit hold word
    input wire logic txEnable, // Transmit enable
    input wire logic rxEnable, // Receive enable
    input wire logic rxBlocked, // Reception blocked
    input wire logic txBlocked, // Transmission blocked
    input wire logic irq // Interrupt
);
    // One clock domain for every property
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!arst_n);
    sequence ctrl_wr;
        regWrEn && regAddr == 4'h1;
    endsequence
    sequence stat_rd;
        regRdEn && regAddr == 4'h0;
    endsequence
    ctrl_load_a: assert property (ctrl_wr |=> txEnable == $past(regWrData[0])
        && rxEnable == $past(regWrData[1])) else $error("control bits not loaded");
    txe_forced_a: assert property (!txEnable && !$past(txEnable) ##0 stat_rd
        |=> regRdData[7]) else $error("tx empty low while disabled");
    hold_src_a: assert property (!$stable(rxHoldData)
        |-> $past(rxDone && rxEnable && !rxBlocked)) else $error("hold word changed");
    blk_clear_a: assert property ($fell(rxBlocked)
        |-> $past(regWrEn && regAddr <= 4'h1)) else $error("block dropped by itself");
    rx_off_a: assert property ($fell(rxEnable) && !$past(rxDone)
        |-> rxBlocked == $past(rxBlocked)) else $error("rx disable changed flags");
    tx_blk_a: assert property (txBlocked |-> rxBlocked) else $error("tx block alone");
    rd_idle_a: assert property (!$past(regRdEn) |-> regRdData == 8'h00)
        else $error("read data outside read slot");
    irq_fall_a: assert property ($fell(irq) |-> $past(regWrEn)) else $error("irq fell alone");
    tx_hold_a: assert property (dtcTxWrite |=> txHoldData == $past(dtcTxData))
        else $error("tx hold not loaded");
endmodule // ssf_status_flags_asserts
bind ssf_status_flags ssf_status_flags_asserts ssf_status_flags_asserts_i (.ref_clk, .arst_n,
    .regAddr, .regWrData, .regWrEn, .regRdEn, .regRdData, .dtcTxWrite, .dtcTxData, .rxDone,
    .rxHoldData, .txHoldData, .txEnable, .rxEnable, .rxBlocked, .txBlocked, .irq);
`default_nettype wire

// File: tb/ssf_peer_model.sv
/* Far-side reception engine model: delivers one word per go pulse.
   Assumes the bench raises go for one cycle and sets lat for the delay. */
`timescale 1ns/1ps
`default_nettype none
module ssf_peer_model (
    input wire logic ref_clk, // Clock
    input wire logic go, // Start one reception
    input wire logic [7:0] goData, // Word to deliver
    input wire logic goStop, // First stop bit level
    input wire logic goPar, // Parity mismatch
    input wire logic [3:0] lat, // Cycles before done
    output wire logic rxDone, // Done pulse
    output wire logic [7:0] rxShiftData, // Word
    output wire logic rxStopBit, // Stop bit
    output wire logic rxParityBad, // Parity flag
    output wire logic rxMpBit // Multiprocessor bit
);
    logic done_ff = 1'b0;
    logic busy_ff = 1'b0;
    logic [3:0] cnt_ff = 4'h0;
    logic [9:0] word_ff = 10'h000;
    // Counts lat cycles, then gives a one-cycle done
    always @(posedge ref_clk) begin
        done_ff <= busy_ff && cnt_ff == 4'h0;
        if (go && !busy_ff) begin
            busy_ff <= 1'b1;
            cnt_ff <= lat;
            word_ff <= {goPar, goStop, goData};
        end else if (busy_ff && cnt_ff != 4'h0) begin
            cnt_ff <= cnt_ff - 4'h1;
        end else begin
            busy_ff <= 1'b0;
        end
    end
    // Outside the pulse the lines carry the inverse, never a stale word
    assign rxDone = done_ff;
    assign rxShiftData = done_ff ? word_ff[7:0] : ~word_ff[7:0];
    assign rxStopBit = done_ff ? word_ff[8] : ~word_ff[8];
    assign rxParityBad = done_ff ? word_ff[9] : ~word_ff[9];
    assign rxMpBit = ~done_ff;
endmodule // ssf_peer_model
`default_nettype wire

// File: tb/ssf_status_flags_tb.sv
/* Self-checking bench for the status flag block.
   Assumes ssf_consts.vh is on the include path. */
`timescale 1ns/1ps
`default_nettype none
`include "ssf_consts.vh"
module ssf_status_flags_tb;
    logic ref_clk = 1'b0, arst_n = 1'b0, regWrEn = 1'b0, regRdEn = 1'b0, go = 1'b0;
    logic txEndIn = 1'b1, errSignalIn = 1'b0, goStop = 1'b1, goPar = 1'b0;
    logic [3:0] regAddr = 4'h0, lat = 4'h0;
    logic [7:0] regWrData = 8'h00, dtcTxData = 8'hA5, goData = 8'h00;
    logic [2:0] ev = 3'h0;
    logic rxDone, rxStopBit, rxParityBad, rxMpBit, txEnable, rxEnable, smartSelect;
    logic twoStopSelect, rxBlocked, txBlocked, multiprocTx, irq;
    logic [7:0] regRdData, rxShiftData, txHoldData, rxHoldData;
    wire txLoadShift = ev[0];
    wire dtcTxWrite = ev[1];
    wire dtcRxRead = ev[2];
    int error_cnt = 0, n_compared = 0;
    always #5 ref_clk = ~ref_clk;
    ssf_status_flags ssf_status_flags_i (.ref_clk, .arst_n, .regAddr, .regWrData, .regWrEn,
        .regRdEn, .regRdData, .txLoadShift, .txEndIn, .dtcTxWrite, .dtcTxData, .dtcRxRead,
        .rxDone, .rxShiftData, .rxStopBit, .rxParityBad, .rxMpBit, .errSignalIn, .txHoldData,
        .rxHoldData, .txEnable, .rxEnable, .smartSelect, .twoStopSelect, .rxBlocked,
        .txBlocked, .multiprocTx, .irq);
    ssf_peer_model ssf_peer_model_i (.ref_clk, .go, .goData, .goStop, .goPar, .lat, .rxDone,
        .rxShiftData, .rxStopBit, .rxParityBad, .rxMpBit);
    task automatic cmp(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        regWrEn <= 1'b1;
        regAddr <= a;
        regWrData <= d;
        @(posedge ref_clk);
        regWrEn <= 1'b0;
        #1;
    endtask
    task automatic stat(input logic [7:0] m, input logic [7:0] exp);
        @(posedge ref_clk);
        regRdEn <= 1'b1;
        regAddr <= `SSF_OFS_STATUS;
        @(posedge ref_clk);
        regRdEn <= 1'b0;
        #1 cmp("status", exp, regRdData & m);
    endtask
    // One-cycle event pulse from the shift engine or controller
    task automatic pulse(input logic [2:0] m);
        @(posedge ref_clk);
        ev <= m;
        @(posedge ref_clk);
        ev <= 3'h0;
    endtask
    task automatic peer(input logic [7:0] d, input logic s, input logic p);
        int i;
        @(posedge ref_clk);
        go <= 1'b1;
        goData <= d;
        goStop <= s;
        goPar <= p;
        @(posedge ref_clk);
        go <= 1'b0;
        for (i = 0; i < 40 && rxDone !== 1'b1; i++) @(posedge ref_clk) #1;
        if (rxDone !== 1'b1) begin
            error_cnt++;
            final_report();
        end
        @(posedge ref_clk) #1;
    endtask
    task automatic t_tx;
        stat(8'hFF, 8'h84);
        wr(`SSF_OFS_CONTROL, 8'h01);
        wr(`SSF_OFS_STATUS, 8'hFF);
        stat(8'h80, 8'h80);
        wr(`SSF_OFS_TXHOLD, 8'h5A);
        wr(`SSF_OFS_STATUS, 8'h7F);
        stat(8'h80, 8'h00);
        cmp("txHold", 8'h5A, txHoldData);
        pulse(3'h1);
        wr(`SSF_OFS_STATUS, 8'h7B);
        stat(8'h84, 8'h84);
        cmp("mpTx", 8'h01, {7'h00, multiprocTx});
        pulse(3'h2);
        stat(8'h80, 8'h00);
        cmp("txHold", 8'hA5, txHoldData);
        wr(`SSF_OFS_CONTROL, 8'h00);
        wr(`SSF_OFS_STATUS, 8'h7F);
        stat(8'h80, 8'h80);
        $display("test tx done");
    endtask
    task automatic t_rx;
        wr(`SSF_OFS_IRQ_MASK, 8'h06);
        wr(`SSF_OFS_CONTROL, 8'h02);
        peer(8'h3C, 1'b1, 1'b0);
        cmp("rxHold", 8'h3C, rxHoldData);
        cmp("irq", 8'h01, {7'h00, irq});
        lat <= 4'h5;
        peer(8'hC3, 1'b1, 1'b0);
        stat(8'h60, 8'h60);
        peer(8'h55, 1'b1, 1'b0);
        cmp("rxHold", 8'h3C, rxHoldData);
        wr(`SSF_OFS_CONTROL, 8'h00);
        stat(8'h60, 8'h60);
        wr(`SSF_OFS_CONTROL, 8'h02);
        pulse(3'h4);
        stat(8'h60, 8'h20);
        wr(`SSF_OFS_STATUS, 8'hDF);
        stat(8'h20, 8'h00);
        wr(`SSF_OFS_IRQ_STAT, 8'h07);
        cmp("irq", 8'h00, {7'h00, irq});
        peer(8'h81, 1'b0, 1'b0);
        stat(8'h50, 8'h10);
        cmp("rxHold", 8'h81, rxHoldData);
        wr(`SSF_OFS_STATUS, 8'hEF);
        peer(8'h42, 1'b1, 1'b1);
        stat(8'h58, 8'h08);
        cmp("rxHold", 8'h42, rxHoldData);
        wr(`SSF_OFS_CONTROL, 8'h1E);
        cmp("ctrlOut", 8'h0F, {4'h0, smartSelect, twoStopSelect, txBlocked, rxBlocked});
        @(posedge ref_clk) errSignalIn <= 1'b1;
        @(posedge ref_clk) errSignalIn <= 1'b0;
        stat(8'h10, 8'h10);
        $display("test rx done");
    endtask
    task final_report;
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge ref_clk);
        arst_n <= 1'b1;
        t_tx();
        t_rx();
        final_report();
    end
endmodule // ssf_status_flags_tb
`default_nettype wire
